// *** testbench/flash_array_model.sv ***
// Behavioural flash array that records the sequencer's strobes.
`timescale 1ns/1ps
module flash_array_model
    import flash_seq_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            wr_i,
    input  wire logic            erase_i,
    input  wire logic [TP_W-1:0] addr_i,
    input  wire logic [7:0]      data_i
);
    int              wr_n   = 0;
    int              er_n   = 0;
    logic [TP_W-1:0] last_a = '0;
    logic [7:0]      last_d = '0;
    logic [TP_W-1:0] er_a   = '0;
    logic [7:0]      mem [2**ROW_AW];

    initial
    begin
        foreach (mem[i])
            mem[i] = ERASED_BYTE;
    end

    // Each strobe is one byte or one row; nothing wider exists here.
    always @(posedge clk_i)
    begin
        if (wr_i === 1'b1)
        begin
            wr_n++;
            last_a = addr_i;
            last_d = data_i;
            // Programming can only clear bits of a byte.
            mem[addr_i[ROW_AW-1:0]] = mem[addr_i[ROW_AW-1:0]] & data_i;
        end
        if (erase_i === 1'b1)
        begin
            er_n++;
            er_a = addr_i;
            foreach (mem[i])
                mem[i] = ERASED_BYTE;
        end
    end
endmodule : flash_array_model

// *** testbench/tb_flash_row_program_sequencer.sv ***
// Self-checking bench for the flash row program sequencer.
`timescale 1ns/1ps
module tb_flash_row_program_sequencer
    import flash_seq_pkg::*;
;
    localparam logic [TMR_W-1:0] CYC = 16'h0040;
    logic            clk_i = 0;
    logic            rst_i = 1;
    logic            cyc   = 0;
    logic            stb   = 0;
    logic            we    = 0;
    logic [7:0]      adr   = '0;
    logic [3:0]      sel   = '0;
    logic [31:0]     dat   = '0;
    logic [31:0]     rd;
    logic            ack;
    logic            irq;
    logic            stall;
    logic [TP_W-1:0] fa;
    logic [7:0]      fd;
    logic            fw;
    logic            fe;
    int              fails   = 0;
    int              checked = 0;
    int              n;
    int              w0;

    flash_row_program_sequencer #(.PROG_CYCLES_P(CYC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .irq_o(irq), .cpu_stall_o(stall), .flash_addr_o(fa),
        .flash_data_o(fd), .flash_wr_o(fw), .flash_erase_o(fe));

    flash_array_model i_flash (.clk_i(clk_i), .wr_i(fw), .erase_i(fe),
        .addr_i(fa), .data_i(fd));

    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("counts: checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask : chk

    // The request stays up until ack is sampled; a hung slave ends the run.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        q = rd;
        cyc <= 0;
        stb <= 0;
        // Let the edge's updates settle before anyone looks at outputs.
        @(negedge clk_i);
        if (k >= 20)
        begin
            fails++;
            test_done();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e, input string s);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q & m, e, s);
    endtask : rdchk

    // Unlock, launch, then count the stall length in cycles.
    task automatic launch(input logic [7:0] v, output int c);
        wr(OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY1});
        wr(OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY2});
        wr(OFS_CTRL, {24'h00_0000, v});
        c = 0;
        for (int i = 0; i < 300; i++)
        begin
            if (stall === 1'b1)
                c++;
            else if (c > 0)
                break;
            @(negedge clk_i);
        end
        if (stall === 1'b1 || c == 0)
        begin
            fails++;
            test_done();
        end
    endtask : launch

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl reset");
        rdchk(OFS_IRQ_STAT, 32'hFFFF_FFFF, 32'h0, "stat reset");
        rdchk(8'h20, 32'hFFFF_FFFF, 32'h0, "unmapped read");
        chk(irq, 1'b0, "irq reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_prog;
        wr(OFS_PTR, 32'h0000_0040);
        for (int i = 0; i < 4; i++)
            wr(OFS_TWR_INC, 32'h10 + i);
        wr(OFS_IRQ_EN, 32'h1);
        w0 = i_flash.wr_n;
        launch(8'h86, n);
        chk(n, CYC, "stall length");
        chk(i_flash.wr_n - w0, 4, "bytes written");
        chk(i_flash.last_a, 21'h00_0043, "last address");
        chk(i_flash.last_d, 8'h13, "last data");
        for (int i = 0; i < 4; i++)
            chk(i_flash.mem[i], 8'h10 + i, "read back");
        chk(i_flash.mem[4], ERASED_BYTE, "untouched byte");
        rdchk(OFS_CTRL, 32'h2, 32'h0, "start cleared");
        chk(irq, 1'b1, "done irq");
        wr(OFS_IRQ_CLR, 32'h1);
        chk(irq, 1'b0, "irq cleared");
        w0 = i_flash.wr_n;
        launch(8'h86, n);
        chk(i_flash.wr_n - w0, 0, "holding back to erased");
        wr(OFS_IRQ_CLR, 32'h1);
        $display("test program done");
    endtask : t_prog

    task automatic t_refuse;
        wr(OFS_CTRL, 32'h86);
        repeat (3) @(negedge clk_i);
        chk(stall, 1'b0, "start without unlock");
        rdchk(OFS_CTRL, 32'hA, 32'h8, "abort flag");
        rdchk(OFS_IRQ_STAT, 32'h3, 32'h2, "abort status");
        chk(irq, 1'b0, "abort masked");
        wr(OFS_IRQ_EN, 32'h3);
        chk(irq, 1'b1, "abort enabled");
        wr(OFS_IRQ_CLR, 32'h3);
        chk(irq, 1'b0, "abort cleared");
        wr(OFS_CTRL, 32'h0);
        rdchk(OFS_CTRL, 32'h8, 32'h0, "abort flag cleared");
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_erase;
        wr(OFS_PTR, 32'h0000_005A);
        w0 = i_flash.er_n;
        launch(8'h96, n);
        chk(i_flash.er_n - w0, 1, "one erase");
        chk(i_flash.er_a, 21'h00_0040, "erase row base");
        chk(i_flash.mem[0], ERASED_BYTE, "row erased");
        rdchk(OFS_CTRL, 32'h12, 32'h0, "erase bit cleared");
        $display("test erase done");
    endtask : t_erase

    task automatic t_abort;
        wr(OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY1});
        wr(OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY2});
        wr(OFS_CTRL, 32'h86);
        repeat (10) @(posedge clk_i);
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        rdchk(OFS_CTRL, 32'hCA, 32'h88, "reset while busy");
        chk(stall, 1'b0, "stall ends at reset");
        $display("test abort done");
    endtask : t_abort

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_prog();
        t_refuse();
        t_erase();
        t_abort();
        test_done();
    end
endmodule : tb_flash_row_program_sequencer

// *** verilog/flash_row_program_sequencer.sv ***
// Flash row program sequencer: holding registers, unlock, long write.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module flash_row_program_sequencer
    import flash_seq_pkg::*;
#(
    parameter logic [TMR_W-1:0] PROG_CYCLES_P = PROG_CYCLES
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             cpu_stall_o,
    output logic [TP_W-1:0]  flash_addr_o,
    output logic [7:0]       flash_data_o,
    output logic             flash_wr_o,
    output logic             flash_erase_o
);
    hold_if hif ();

    seq_state_t      state_q, state_d;
    unlock_state_t   ul_q, ul_d;
    logic            ack_q, ack_d;
    logic [31:0]     dat_q, dat_d;
    logic            pgm_q, pgm_d;
    logic            cfg_q, cfg_d;
    logic            erase_q, erase_d;
    logic            permit_q, permit_d;
    logic            start_q, start_d;
    logic            abort_q, abort_d;
    logic [TP_W-1:0] ptr_q, ptr_d;
    logic [IRQ_W-1:0] stat_q, stat_d;
    logic [IRQ_W-1:0] en_q, en_d;
    logic [5:0]      idx_q, idx_d;
    logic            rdv_q, rdv_d;
    logic [HOLD_AW-1:0] ridx_q, ridx_d;
    logic [TP_W-1:0] faddr_q, faddr_d;
    logic [7:0]      fdata_q, fdata_d;
    logic            fwr_q, fwr_d;
    logic            fer_q, fer_d;
    logic            req, wr_go, busy, tmr_done;
    logic            attempt, legal, go, bad;
    logic [IRQ_W-1:0] ev;

    hold_regs u_hold (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .hif   (hif)
    );

    prog_timer #(
        .CYCLES (PROG_CYCLES_P)
    ) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .start_i (go),
        .done_o  (tmr_done)
    );

    // --------------------------------------------------------------
    // Bus decode and launch qualification
    // --------------------------------------------------------------
    // A write commits at the edge where the master sees ack high.
    assign req     = wb_cyc_i && wb_stb_i;
    assign wr_go   = req && wb_we_i && ack_q && wb_sel_i[0];
    assign busy    = (state_q != ST_IDLE);
    assign attempt = wr_go && (wb_adr_i == OFS_CTRL) && !busy
                     && wb_dat_i[CB_START] && !start_q;
    assign legal   = (ul_q == UL_KEY2) && wb_dat_i[CB_PERMIT]
                     && wb_dat_i[CB_PGM] && !wb_dat_i[CB_CFG];
    assign go      = attempt && legal;
    assign bad     = attempt && !legal;
    assign cpu_stall_o = busy;

    // Table writes go only to holding registers, never while busy.
    assign hif.we    = wr_go && !busy && ((wb_adr_i == OFS_TWR)
                       || (wb_adr_i == OFS_TWR_INC));
    assign hif.waddr = ptr_q[HOLD_AW-1:0];
    assign hif.wdata = wb_dat_i[7:0];
    assign hif.raddr = idx_q[HOLD_AW-1:0];
    assign hif.clear = (state_q == ST_PROG) && tmr_done;

    // --------------------------------------------------------------
    // Sequencer state
    // --------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        idx_d   = idx_q;
        rdv_d   = 1'b0;
        ridx_d  = idx_q[HOLD_AW-1:0];
        fer_d   = 1'b0;
        ev      = '0;
        if (rst_i)
        begin
            state_d = ST_IDLE;
            idx_d   = '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    idx_d = '0;
                    if (go && wb_dat_i[CB_ERASE])
                    begin
                        state_d = ST_ERASE;
                        fer_d   = 1'b1;
                    end
                    else if (go)
                        state_d = ST_PROG;
                end
                ST_ERASE:
                begin
                    if (tmr_done)
                    begin
                        state_d     = ST_IDLE;
                        ev[IB_DONE] = 1'b1;
                    end
                end
                ST_PROG:
                begin
                    // Each holding byte is offered once; the block
                    // is committed as a whole.
                    if (!idx_q[HOLD_AW])
                    begin
                        idx_d = idx_q + 6'h01;
                        rdv_d = 1'b1;
                    end
                    if (tmr_done)
                    begin
                        state_d     = ST_IDLE;
                        ev[IB_DONE] = 1'b1;
                    end
                end
                default:
                    state_d = ST_IDLE;
            endcase
        end
        ev[IB_ABORT] = bad || (rst_i && busy);
    end

    // --------------------------------------------------------------
    // Flash strobes
    // --------------------------------------------------------------
    always_comb
    begin
        fwr_d   = rdv_q && (hif.rdata != ERASED_BYTE);
        fdata_d = hif.rdata;
        faddr_d = {ptr_q[TP_W-1:HOLD_AW], ridx_q};
        if (fer_d)
            faddr_d = {ptr_q[TP_W-1:ROW_AW], ROW_AW'(0)};
        else if (!rdv_q)
            faddr_d = faddr_q;
        if (rst_i)
            fwr_d = 1'b0;
    end

    // --------------------------------------------------------------
    // Registers, unlock and interrupts
    // --------------------------------------------------------------
    always_comb
    begin
        ack_d    = req && !ack_q;
        dat_d    = '0;
        ul_d     = ul_q;
        pgm_d    = pgm_q;
        cfg_d    = cfg_q;
        erase_d  = erase_q;
        permit_d = permit_q;
        start_d  = start_q;
        abort_d  = abort_q;
        ptr_d    = ptr_q;
        en_d     = en_q;
        stat_d   = stat_q;
        case (wb_adr_i)
            OFS_CTRL:     dat_d[7:0] = {pgm_q, cfg_q, 1'b0, erase_q,
                              abort_q, permit_q, start_q, 1'b0};
            OFS_PTR:      dat_d[TP_W-1:0] = ptr_q;
            OFS_IRQ_STAT: dat_d[IRQ_W-1:0] = stat_q;
            OFS_IRQ_EN:   dat_d[IRQ_W-1:0] = en_q;
            default:      dat_d = '0;
        endcase
        if (wr_go)
        begin
            ul_d = UL_NONE;
            if (wb_adr_i == OFS_UNLOCK && wb_dat_i[7:0] == UNLOCK_KEY1)
                ul_d = UL_KEY1;
            if (wb_adr_i == OFS_UNLOCK && wb_dat_i[7:0] == UNLOCK_KEY2
                && ul_q == UL_KEY1)
                ul_d = UL_KEY2;
            if (wb_adr_i == OFS_CTRL && !busy)
            begin
                pgm_d    = wb_dat_i[CB_PGM];
                cfg_d    = wb_dat_i[CB_CFG];
                erase_d  = wb_dat_i[CB_ERASE];
                permit_d = wb_dat_i[CB_PERMIT];
                abort_d  = wb_dat_i[CB_ABORT] && abort_q;
                start_d  = start_q || go;
            end
            if (wb_adr_i == OFS_PTR && !busy)
            begin
                ptr_d[7:0]   = wb_dat_i[7:0];
                if (wb_sel_i[1])
                    ptr_d[15:8] = wb_dat_i[15:8];
                if (wb_sel_i[2])
                    ptr_d[TP_W-1:16] = wb_dat_i[TP_W-1:16];
            end
            if (wb_adr_i == OFS_TWR_INC && !busy)
                ptr_d = ptr_q + TP_W'(1);
            if (wb_adr_i == OFS_IRQ_EN)
                en_d = wb_dat_i[IRQ_W-1:0];
            if (wb_adr_i == OFS_IRQ_CLR)
                stat_d = stat_q & ~wb_dat_i[IRQ_W-1:0];
        end
        if (tmr_done && busy)
        begin
            start_d = 1'b0;
            if (state_q == ST_ERASE)
                erase_d = 1'b0;
        end
        if (ev[IB_ABORT])
            abort_d = 1'b1;
        stat_d = stat_d | ev;
        if (rst_i)
        begin
            // A reset that cuts a write short keeps the program and config selects so
            // software can trace what was interrupted.
            ack_d    = 1'b0;
            ul_d     = UL_NONE;
            pgm_d    = busy && pgm_q;
            cfg_d    = busy && cfg_q;
            erase_d  = 1'b0;
            permit_d = 1'b0;
            start_d  = 1'b0;
            abort_d  = busy;
            ptr_d    = '0;
            en_d     = '0;
            stat_d   = {busy, 1'b0};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || ce_i)
        begin
            state_q  <= state_d;
            idx_q    <= idx_d;
            rdv_q    <= rdv_d;
            ridx_q   <= ridx_d;
            faddr_q  <= faddr_d;
            fdata_q  <= fdata_d;
            fwr_q    <= fwr_d;
            fer_q    <= fer_d;
            ack_q    <= ack_d;
            dat_q    <= dat_d;
            ul_q     <= ul_d;
            pgm_q    <= pgm_d;
            cfg_q    <= cfg_d;
            erase_q  <= erase_d;
            permit_q <= permit_d;
            start_q  <= start_d;
            abort_q  <= abort_d;
            ptr_q    <= ptr_d;
            en_q     <= en_d;
            stat_q   <= stat_d;
        end
    end

    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = dat_q;
    assign irq_o         = |(stat_q & en_q);
    assign flash_addr_o  = faddr_q;
    assign flash_data_o  = fdata_q;
    assign flash_wr_o    = fwr_q;
    assign flash_erase_o = fer_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_unlock;
        @(posedge clk_i) disable iff (rst_i)
        $rose(cpu_stall_o) |-> $past(ul_q == UL_KEY2);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("write launched without unlock");

    property p_stall_len;
        @(posedge clk_i) disable iff (rst_i)
        $rose(cpu_stall_o) |=> cpu_stall_o [*8];
    endproperty
    a_stall_len: assert property (p_stall_len)
        else $error("stall ended too soon");

    property p_start_hw_clear;
        @(posedge clk_i) disable iff (rst_i)
        $fell(start_q) |-> $past(tmr_done || rst_i);
    endproperty
    a_start_hw_clear: assert property (p_start_hw_clear)
        else $error("write-start cleared without completion");

    property p_skip_erased;
        @(posedge clk_i) disable iff (rst_i)
        flash_wr_o |-> (flash_data_o != ERASED_BYTE);
    endproperty
    a_skip_erased: assert property (p_skip_erased)
        else $error("erased holding byte sent to flash");

    property p_short_write;
        @(posedge clk_i) disable iff (rst_i)
        hif.we |-> !cpu_stall_o && !flash_wr_o;
    endproperty
    a_short_write: assert property (p_short_write)
        else $error("table write during long write");

    property p_erase_clear;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_ERASE && tmr_done && ce_i)
            |=> !erase_q && !start_q && stat_q[IB_DONE];
    endproperty
    a_erase_clear: assert property (p_erase_clear)
        else $error("row-erase bit not cleared on completion");

    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        (bad && ce_i) |=> abort_q && !cpu_stall_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("improper start not flagged");

    property p_block;
        @(posedge clk_i) disable iff (rst_i)
        flash_wr_o |-> flash_addr_o[TP_W-1:HOLD_AW]
            == ptr_q[TP_W-1:HOLD_AW];
    endproperty
    a_block: assert property (p_block)
        else $error("flash byte outside the holding block");

    c_prog: cover property (@(posedge clk_i) state_q == ST_PROG
        && tmr_done);
    c_erase: cover property (@(posedge clk_i) flash_erase_o);
    c_abort: cover property (@(posedge clk_i) bad);
endmodule : flash_row_program_sequencer

// *** verilog/flash_seq_pkg.sv ***
// Constants, register map and state types of the flash row sequencer.
package flash_seq_pkg;
    // --------------------------------------------------------------
    // Register map (byte offsets on the register bus)
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_UNLOCK   = 8'h04;
    localparam logic [7:0] OFS_PTR      = 8'h08;
    localparam logic [7:0] OFS_TWR      = 8'h0C;
    localparam logic [7:0] OFS_TWR_INC  = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h1C;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int CB_PGM    = 7;
    localparam int CB_CFG    = 6;
    localparam int CB_ERASE  = 4;
    localparam int CB_ABORT  = 3;
    localparam int CB_PERMIT = 2;
    localparam int CB_START  = 1;
    localparam int IB_DONE   = 0;
    localparam int IB_ABORT  = 1;
    localparam int IRQ_W     = 2;
    // --------------------------------------------------------------
    // Sizes, keys and timing
    // --------------------------------------------------------------
    localparam int HOLD_N  = 32;
    localparam int HOLD_AW = 5;
    localparam int ROW_AW  = 6;
    localparam int TP_W    = 21;
    localparam int TMR_W   = 16;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_US  = 2000;
    localparam logic [TMR_W-1:0] PROG_CYCLES =
        TMR_W'(PROG_TIME_US * 1000 / CLK_PERIOD_NS);
    // --------------------------------------------------------------
    // State types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG  = 3'b100
    } seq_state_t;
    typedef enum logic [2:0] {
        UL_NONE = 3'b001,
        UL_KEY1 = 3'b010,
        UL_KEY2 = 3'b100
    } unlock_state_t;
endpackage : flash_seq_pkg

// *** verilog/hold_if.sv ***
// Interface between the sequencer and its holding registers.
`timescale 1ns/1ps
interface hold_if;
    import flash_seq_pkg::*;
    logic               we;
    logic [HOLD_AW-1:0] waddr;
    logic [7:0]         wdata;
    logic [HOLD_AW-1:0] raddr;
    logic [7:0]         rdata;
    logic               clear;
    modport ctrl (output we, waddr, wdata, raddr, clear, input rdata);
    modport mem  (input we, waddr, wdata, raddr, clear, output rdata);
endinterface : hold_if

// *** verilog/hold_regs.sv ***
// Thirty-two byte holding registers with a registered read port.
`timescale 1ns/1ps
module hold_regs
    import flash_seq_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    hold_if.mem       hif
);
    logic [7:0]        ent_q [HOLD_N];
    logic [7:0]        ent_d [HOLD_N];
    logic [HOLD_N-1:0] is_erased;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;

    // --------------------------------------------------------------
    // Entries
    // --------------------------------------------------------------
    for (genvar g = 0; g < HOLD_N; g++)
    begin : g_ent
        always_comb
        begin
            ent_d[g] = ent_q[g];
            if (rst_i || hif.clear)
                ent_d[g] = ERASED_BYTE;
            else if (hif.we && hif.waddr == HOLD_AW'(g))
                ent_d[g] = hif.wdata;
        end
        always_ff @(posedge clk_i)
        begin
            if (rst_i || ce_i)
                ent_q[g] <= ent_d[g];
        end
        assign is_erased[g] = (ent_q[g] == ERASED_BYTE);
    end

    always_comb
    begin
        rdata_d = ent_q[hif.raddr];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i || ce_i)
            rdata_q <= rdata_d;
    end
    assign hif.rdata = rdata_q;

    property p_clear_all;
        @(posedge clk_i) disable iff (rst_i)
        (hif.clear && ce_i) |=> (&is_erased);
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("holding registers not erased after clear");
endmodule : hold_regs

// *** verilog/prog_timer.sv ***
// Self-timed programming interval counter.
`timescale 1ns/1ps
module prog_timer
    import flash_seq_pkg::*;
#(
    parameter logic [TMR_W-1:0] CYCLES = PROG_CYCLES
)(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic start_i,
    output logic      done_o
);
    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;
    logic             run_q;
    logic             run_d;

    assign done_o = run_q && (cnt_q == TMR_W'(1));

    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (rst_i)
        begin
            cnt_d = '0;
            run_d = 1'b0;
        end
        else if (start_i)
        begin
            cnt_d = CYCLES;
            run_d = 1'b1;
        end
        else if (done_o)
            run_d = 1'b0;
        else if (run_q)
            cnt_d = cnt_q - TMR_W'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || ce_i)
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end

    property p_min_len;
        @(posedge clk_i) disable iff (rst_i)
        (start_i && ce_i) |=> (!done_o) [*8];
    endproperty
    a_min_len: assert property (p_min_len)
        else $error("programming interval ended too early");
endmodule : prog_timer
